// >>> rtl/ipa_pkg.sv
// Shared constants and types for the indirect pointer access ports
package ipa_pkg;
	// Data path and pointer widths
	localparam int IPA_DATA_W = 8;
	localparam int IPA_ADDR_W = 12;
	localparam int IPA_PTR_W = 12;
	localparam int IPA_PTR_HIGH_W = 4;
	localparam int IPA_PC_W = 21;
	localparam int IPA_MEM_DEPTH = 2048;

	// Data-space addresses of the block's locations
	localparam logic [11:0] IPA_ADDR_WORK = 12'hFE8;
	localparam logic [11:0] IPA_ADDR_PTR_LOW = 12'hFE9;
	localparam logic [11:0] IPA_ADDR_PTR_HIGH = 12'hFEA;
	localparam logic [11:0] IPA_ADDR_OFFSET = 12'hFEB;
	localparam logic [11:0] IPA_ADDR_PRE_INC = 12'hFEC;
	localparam logic [11:0] IPA_ADDR_POST_DEC = 12'hFED;
	localparam logic [11:0] IPA_ADDR_POST_INC = 12'hFEE;
	localparam logic [11:0] IPA_ADDR_PLAIN = 12'hFEF;
	localparam logic [11:0] IPA_ADDR_PC_LOW = 12'hFF9;

	// Field positions and reset values
	localparam int IPA_PTR_LOW_LSB = 0;
	localparam int IPA_PTR_HIGH_LSB = 8;
	localparam logic [3:0] IPA_PTR_HIGH_RST = 4'h0;
	localparam logic [7:0] IPA_WORK_RST = 8'h00;
	localparam logic [7:0] IPA_READ_ZERO = 8'h00;
	localparam logic [11:0] IPA_PTR_STEP = 12'h001;

	// Pointer update applied by an access
	typedef enum logic [2:0] {
		IPA_MODE_NONE,
		IPA_MODE_PLAIN,
		IPA_MODE_POST_INC,
		IPA_MODE_POST_DEC,
		IPA_MODE_PRE_INC,
		IPA_MODE_OFFSET
	} ipa_mode_t;
endpackage

// >>> rtl/ipa_ptr_unit.sv
// Target address and next pointer value for one indirect access
`timescale 1ns/100ps
`default_nettype none
module ipa_ptr_unit import ipa_pkg::*; (
	input wire ipa_mode_t mode_in,
	input wire logic [IPA_PTR_W-1:0] ptr_in,
	input wire logic [IPA_DATA_W-1:0] work_in,
	output logic [IPA_PTR_W-1:0] target_out,
	output logic [IPA_PTR_W-1:0] ptr_nxt_out
);
	logic [IPA_PTR_W-1:0] offset;

	// Working register is a signed byte offset, sign-extended to pointer width
	always_comb begin
		offset = {{(IPA_PTR_W-IPA_DATA_W){work_in[IPA_DATA_W-1]}}, work_in};
		target_out = ptr_in;
		ptr_nxt_out = ptr_in;
		unique case (mode_in)
			IPA_MODE_NONE, IPA_MODE_PLAIN: begin
				target_out = ptr_in;
			end
			IPA_MODE_POST_INC: begin
				ptr_nxt_out = ptr_in + IPA_PTR_STEP;
			end
			IPA_MODE_POST_DEC: begin
				ptr_nxt_out = ptr_in - IPA_PTR_STEP;
			end
			IPA_MODE_PRE_INC: begin
				target_out = ptr_in + IPA_PTR_STEP;
				ptr_nxt_out = ptr_in + IPA_PTR_STEP;
			end
			IPA_MODE_OFFSET: begin
				target_out = ptr_in + offset;
			end
		endcase
	end
endmodule
`default_nettype wire

// >>> rtl/ipa_data_mem.sv
// Byte-wide data memory with registered read data
`timescale 1ns/100ps
`default_nettype none
module ipa_data_mem import ipa_pkg::*; #(
	parameter int DEPTH = IPA_MEM_DEPTH,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic we_in,
	input wire logic re_in,
	input wire logic [AW-1:0] addr_in,
	input wire logic [IPA_DATA_W-1:0] wdata_in,
	output logic [IPA_DATA_W-1:0] rdata_out
);
	logic [IPA_DATA_W-1:0] mem [DEPTH];
	logic [IPA_DATA_W-1:0] rdata_r;
	logic [IPA_DATA_W-1:0] rdata_nxt;

	// Array has no reset, like general purpose RAM
	always_ff @(posedge clk_in) begin
		if (we_in) begin
			mem[addr_in] <= wdata_in;
		end
	end

	// Read word held until the next read
	always_comb begin
		rdata_nxt = re_in ? mem[addr_in] : rdata_r;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_r <= IPA_READ_ZERO;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_out = rdata_r;
endmodule
`default_nettype wire

// >>> rtl/ipa_pointer_ports.sv
// Indirect pointer 0 access ports, working register and program counter low byte
//
// Function
// - Indirect locations access memory at pointer address.
// - Post-increment: use pointer, then add one.
// - Post-decrement: use pointer, then subtract one.
// - Pre-increment: add one, then use pointer.
// - Offset location addresses pointer plus working register.
// - Program counter low location shows bits 7:0.
// - Pointer in two bytes; low byte unreset.
`timescale 1ns/100ps
`default_nettype none
module ipa_pointer_ports import ipa_pkg::*; #(
	parameter int MEM_DEPTH = IPA_MEM_DEPTH,
	parameter int PC_W = IPA_PC_W
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [IPA_ADDR_W-1:0] bus_addr_in,
	input wire logic [IPA_DATA_W-1:0] bus_wdata_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic [PC_W-1:0] program_counter_in,
	output logic [IPA_DATA_W-1:0] bus_rdata_out,
	output logic pc_low_wr_out,
	output logic [IPA_DATA_W-1:0] pc_low_wdata_out,
	output logic [IPA_PTR_W-1:0] indirect_pointer_zero_out
);
	localparam int MEM_AW = $clog2(MEM_DEPTH);

	ipa_mode_t mode;
	logic access;
	logic indirect;
	logic [IPA_PTR_W-1:0] target;
	logic [IPA_PTR_W-1:0] unit_ptr_nxt;
	logic [IPA_ADDR_W-1:0] sel_addr;
	logic mem_hit;
	logic mem_we;
	logic mem_re;
	logic [IPA_DATA_W-1:0] mem_q;
	logic [IPA_DATA_W-1:0] reg_val;

	logic [7:0] indirect_pointer_zero_low_r;
	logic [7:0] indirect_pointer_zero_low_nxt;
	logic [IPA_PTR_HIGH_W-1:0] indirect_pointer_zero_high_r;
	logic [IPA_PTR_HIGH_W-1:0] indirect_pointer_zero_high_nxt;
	logic [IPA_DATA_W-1:0] work_r;
	logic [IPA_DATA_W-1:0] work_nxt;
	logic pc_wr_r;
	logic pc_wr_nxt;
	logic [IPA_DATA_W-1:0] pc_data_r;
	logic [IPA_DATA_W-1:0] pc_data_nxt;
	logic rd_valid_r;
	logic rd_valid_nxt;
	logic src_mem_r;
	logic src_mem_nxt;
	logic [IPA_DATA_W-1:0] reg_q_r;
	logic [IPA_DATA_W-1:0] reg_q_nxt;
	logic low_known_r;
	logic low_known_nxt;

	assign indirect_pointer_zero_out = {indirect_pointer_zero_high_r, indirect_pointer_zero_low_r};

	// Address decode of the five virtual locations
	always_comb begin
		case (bus_addr_in)
			IPA_ADDR_PLAIN: mode = IPA_MODE_PLAIN;
			IPA_ADDR_POST_INC: mode = IPA_MODE_POST_INC;
			IPA_ADDR_POST_DEC: mode = IPA_MODE_POST_DEC;
			IPA_ADDR_PRE_INC: mode = IPA_MODE_PRE_INC;
			IPA_ADDR_OFFSET: mode = IPA_MODE_OFFSET;
			default: mode = IPA_MODE_NONE;
		endcase
		access = bus_rd_in | bus_wr_in;
		indirect = access && (mode != IPA_MODE_NONE);
	end

	ipa_ptr_unit u_ptr_unit (
		.mode_in(mode),
		.ptr_in(indirect_pointer_zero_out),
		.work_in(work_r),
		.target_out(target),
		.ptr_nxt_out(unit_ptr_nxt)
	);

	// Memory port: indirect target or direct address; targets above RAM read zero
	always_comb begin
		sel_addr = indirect ? target : bus_addr_in;
		mem_hit = 32'(sel_addr) < MEM_DEPTH;
		mem_we = bus_wr_in && mem_hit;
		mem_re = bus_rd_in && mem_hit;
	end

	ipa_data_mem #(
		.DEPTH(MEM_DEPTH),
		.AW(MEM_AW)
	) u_data_mem (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.we_in(mem_we),
		.re_in(mem_re),
		.addr_in(sel_addr[MEM_AW-1:0]),
		.wdata_in(bus_wdata_in),
		.rdata_out(mem_q)
	);

	// Physical register read mux; the virtual locations are not storage
	always_comb begin
		case (bus_addr_in)
			IPA_ADDR_WORK: reg_val = work_r;
			IPA_ADDR_PTR_LOW: reg_val = indirect_pointer_zero_low_r;
			IPA_ADDR_PTR_HIGH: reg_val = {4'h0, indirect_pointer_zero_high_r};
			IPA_ADDR_PC_LOW: reg_val = program_counter_in[7:0];
			default: reg_val = IPA_READ_ZERO;
		endcase
	end

	// Next pointer, working register and program counter write request
	always_comb begin
		indirect_pointer_zero_low_nxt = indirect_pointer_zero_low_r;
		indirect_pointer_zero_high_nxt = indirect_pointer_zero_high_r;
		work_nxt = work_r;
		pc_wr_nxt = 1'b0;
		pc_data_nxt = pc_data_r;
		if (indirect) begin
			// Same update for read and write, once per strobe
			indirect_pointer_zero_low_nxt = unit_ptr_nxt[7:0];
			indirect_pointer_zero_high_nxt = unit_ptr_nxt[IPA_PTR_W-1:IPA_PTR_HIGH_LSB];
		end else if (bus_wr_in) begin
			case (bus_addr_in)
				IPA_ADDR_PTR_LOW: indirect_pointer_zero_low_nxt = bus_wdata_in;
				IPA_ADDR_PTR_HIGH: begin
					indirect_pointer_zero_high_nxt = bus_wdata_in[IPA_PTR_HIGH_W-1:0];
				end
				IPA_ADDR_WORK: work_nxt = bus_wdata_in;
				IPA_ADDR_PC_LOW: begin
					pc_wr_nxt = 1'b1;
					pc_data_nxt = bus_wdata_in;
				end
				default: begin
					pc_wr_nxt = 1'b0;
				end
			endcase
		end
	end

	// Low byte left unreset on purpose: its power-up value is undefined
	always_ff @(posedge clk_in) begin
		indirect_pointer_zero_low_r <= indirect_pointer_zero_low_nxt;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			indirect_pointer_zero_high_r <= IPA_PTR_HIGH_RST;
			work_r <= IPA_WORK_RST;
			pc_wr_r <= 1'b0;
			pc_data_r <= IPA_READ_ZERO;
		end else begin
			indirect_pointer_zero_high_r <= indirect_pointer_zero_high_nxt;
			work_r <= work_nxt;
			pc_wr_r <= pc_wr_nxt;
			pc_data_r <= pc_data_nxt;
		end
	end

	assign pc_low_wr_out = pc_wr_r;
	assign pc_low_wdata_out = pc_data_r;

	// Read return path: data stand only in the cycle after the strobe
	always_comb begin
		rd_valid_nxt = bus_rd_in;
		src_mem_nxt = bus_rd_in && mem_hit;
		reg_q_nxt = (bus_rd_in && !indirect) ? reg_val : IPA_READ_ZERO;
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_valid_r <= 1'b0;
			src_mem_r <= 1'b0;
			reg_q_r <= IPA_READ_ZERO;
		end else begin
			rd_valid_r <= rd_valid_nxt;
			src_mem_r <= src_mem_nxt;
			reg_q_r <= reg_q_nxt;
		end
	end

	// Zero outside the answer cycle keeps stale bytes off the bus
	assign bus_rdata_out = !rd_valid_r ? IPA_READ_ZERO : (src_mem_r ? mem_q : reg_q_r);

	// Low byte has no reset; the idle and direct hold checks wait until software has written it
	always_comb begin
		low_known_nxt = low_known_r | (bus_wr_in && bus_addr_in == IPA_ADDR_PTR_LOW);
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			low_known_r <= 1'b0;
		end else begin
			low_known_r <= low_known_nxt;
		end
	end

	// Checks on pointer behaviour and addressing
	property p_plain_addr;
		@(posedge clk_in) disable iff (!reset_n_in)
		(access && bus_addr_in == IPA_ADDR_PLAIN) |->
			(sel_addr == indirect_pointer_zero_out) ##1 $stable(indirect_pointer_zero_out);
	endproperty
	a_plain_addr: assert property (p_plain_addr) else $error("plain port moved pointer");

	property p_post_inc;
		@(posedge clk_in) disable iff (!reset_n_in)
		(access && bus_addr_in == IPA_ADDR_POST_INC) |->
			(sel_addr == indirect_pointer_zero_out)
			##1 (indirect_pointer_zero_out == $past(indirect_pointer_zero_out) + 12'h001);
	endproperty
	a_post_inc: assert property (p_post_inc) else $error("post-increment wrong");

	property p_post_dec;
		@(posedge clk_in) disable iff (!reset_n_in)
		(access && bus_addr_in == IPA_ADDR_POST_DEC) |->
			(sel_addr == indirect_pointer_zero_out)
			##1 (indirect_pointer_zero_out == $past(indirect_pointer_zero_out) - 12'h001);
	endproperty
	a_post_dec: assert property (p_post_dec) else $error("post-decrement wrong");

	property p_pre_inc;
		@(posedge clk_in) disable iff (!reset_n_in)
		(access && bus_addr_in == IPA_ADDR_PRE_INC) |->
			(sel_addr == indirect_pointer_zero_out + 12'h001)
			##1 (indirect_pointer_zero_out == $past(sel_addr));
	endproperty
	a_pre_inc: assert property (p_pre_inc) else $error("pre-increment wrong");

	property p_offset;
		@(posedge clk_in) disable iff (!reset_n_in)
		(access && bus_addr_in == IPA_ADDR_OFFSET) |->
			(sel_addr == indirect_pointer_zero_out + {{4{work_r[7]}}, work_r})
			##1 $stable(indirect_pointer_zero_out);
	endproperty
	a_offset: assert property (p_offset) else $error("offset address wrong");

	property p_pc_low;
		@(posedge clk_in) disable iff (!reset_n_in)
		(bus_rd_in && bus_addr_in == IPA_ADDR_PC_LOW) |->
			##1 (bus_rdata_out == $past(program_counter_in[7:0]));
	endproperty
	a_pc_low: assert property (p_pc_low) else $error("program counter low read wrong");

	property p_high_write;
		@(posedge clk_in) disable iff (!reset_n_in)
		(bus_wr_in && bus_addr_in == IPA_ADDR_PTR_HIGH) |->
			##1 (indirect_pointer_zero_high_r == $past(bus_wdata_in[3:0]));
	endproperty
	a_high_write: assert property (p_high_write) else $error("pointer high write lost");

	property p_idle_hold;
		@(posedge clk_in) disable iff (!reset_n_in)
		(!access && low_known_r) |-> ##1 $stable(indirect_pointer_zero_out);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("pointer changed without access");

	// High nibble is reset, so it is watched from the first cycle
	property p_idle_high;
		@(posedge clk_in) disable iff (!reset_n_in)
		(!access) |-> ##1 $stable(indirect_pointer_zero_high_r);
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("pointer high moved idle");

	property p_mem_read;
		@(posedge clk_in) disable iff (!reset_n_in)
		(bus_rd_in && indirect && !mem_hit) |-> ##1 (bus_rdata_out == 8'h00);
	endproperty
	a_mem_read: assert property (p_mem_read) else $error("unbacked indirect read not zero");

	property p_low_write;
		@(posedge clk_in) disable iff (!reset_n_in)
		(bus_wr_in && bus_addr_in == IPA_ADDR_PTR_LOW) |->
			##1 (indirect_pointer_zero_low_r == $past(bus_wdata_in));
	endproperty
	a_low_write: assert property (p_low_write) else $error("pointer low write lost");

	property p_work_write;
		@(posedge clk_in) disable iff (!reset_n_in)
		(bus_wr_in && bus_addr_in == IPA_ADDR_WORK) |->
			##1 (work_r == $past(bus_wdata_in));
	endproperty
	a_work_write: assert property (p_work_write) else $error("working register write lost");

	// Direct traffic other than pointer writes must leave the pointer alone
	property p_direct_hold;
		@(posedge clk_in) disable iff (!reset_n_in)
		(access && !indirect && low_known_r && !(bus_wr_in
			&& (bus_addr_in == IPA_ADDR_PTR_LOW || bus_addr_in == IPA_ADDR_PTR_HIGH)))
			|-> ##1 $stable(indirect_pointer_zero_out);
	endproperty
	a_direct_hold: assert property (p_direct_hold) else $error("direct access moved pointer");

	property p_pc_write;
		@(posedge clk_in) disable iff (!reset_n_in)
		(bus_wr_in && bus_addr_in == IPA_ADDR_PC_LOW) |->
			##1 (pc_low_wr_out && pc_low_wdata_out == $past(bus_wdata_in));
	endproperty
	a_pc_write: assert property (p_pc_write) else $error("program counter write lost");

	property p_pc_pulse;
		@(posedge clk_in) disable iff (!reset_n_in)
		pc_low_wr_out |-> $past(bus_wr_in && bus_addr_in == IPA_ADDR_PC_LOW);
	endproperty
	a_pc_pulse: assert property (p_pc_pulse) else $error("stray program counter write");

	// Read data must be zero outside the answer cycle
	property p_rdata_idle;
		@(posedge clk_in) disable iff (!reset_n_in)
		(!bus_rd_in) |-> ##1 (bus_rdata_out == IPA_READ_ZERO);
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
endmodule
`default_nettype wire

// >>> test/ipa_core_model.sv
// Core-side model: program counter that takes low-byte writes
`timescale 1ns/100ps
`default_nettype none
module ipa_core_model import ipa_pkg::*; (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic pc_low_wr_in,
	input wire logic [IPA_DATA_W-1:0] pc_low_wdata_in,
	output logic [IPA_PC_W-1:0] pc_out
);
	// Steps by two every cycle without a low-byte write, so a stale sample of the low byte shows up
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pc_out <= 21'h0001A;
		end else if (pc_low_wr_in) begin
			pc_out <= {pc_out[IPA_PC_W-1:8], pc_low_wdata_in};
		end else begin
			pc_out <= pc_out + 21'h00002;
		end
	end
endmodule
`default_nettype wire

// >>> test/indirect_pointer_access_ports_tb.sv
// Self-checking bench for the indirect pointer access ports
`timescale 1ns/100ps
`default_nettype none
module indirect_pointer_access_ports_tb;
	import ipa_pkg::*;
	localparam int DEPTH = 16;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [IPA_ADDR_W-1:0] addr = 12'h000;
	logic [IPA_DATA_W-1:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [IPA_PC_W-1:0] pc;
	logic [IPA_DATA_W-1:0] rdata;
	logic pc_wr;
	logic [IPA_DATA_W-1:0] pc_wdata;
	logic [IPA_PTR_W-1:0] ptr;
	logic [7:0] mem_m [DEPTH];
	logic [11:0] ptr_m;
	logic [7:0] work_m;
	logic [7:0] pcw_m;
	logic [31:0] seed = 32'h00003E5A;
	logic [31:0] r;
	logic [11:0] map [16] = '{12'h000, 12'h003, 12'h009, 12'h00F, 12'hFE8, 12'hFE9,
		12'hFEB, 12'hFEC, 12'hFED, 12'hFEE, 12'hFEF, 12'hFEE, 12'hFEC, 12'hFED,
		12'hFF9, 12'hFF0};
	logic [11:0] modes [5] = '{12'hFEF, 12'hFEE, 12'hFED, 12'hFEC, 12'hFEB};
	int err_total = 0;
	int checks = 0;

	ipa_pointer_ports #(.MEM_DEPTH(DEPTH), .PC_W(IPA_PC_W)) dut_u (.clk_in(clk_in),
		.reset_n_in(reset_n_in), .bus_addr_in(addr), .bus_wdata_in(wdata),
		.bus_wr_in(wr), .bus_rd_in(rd), .program_counter_in(pc), .bus_rdata_out(rdata),
		.pc_low_wr_out(pc_wr), .pc_low_wdata_out(pc_wdata),
		.indirect_pointer_zero_out(ptr));
	ipa_core_model core_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.pc_low_wr_in(pc_wr), .pc_low_wdata_in(pc_wdata), .pc_out(pc));

	// Free-running core clock, 100 ns period
	initial begin
		forever #50 clk_in = ~clk_in;
	end

	function automatic logic [31:0] next_rand();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic bad(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
		bad({24'h000000, got}, {24'h000000, exp});
	endtask

	task automatic cmp_ptr(input logic [11:0] got, input logic [11:0] exp);
		bad({20'h00000, got}, {20'h00000, exp});
	endtask

	task automatic cmp_pcw(input logic [8:0] got, input logic [8:0] exp);
		bad({23'h000000, got}, {23'h000000, exp});
	endtask

	// One bus cycle; the reference is updated in step and checked after the answer
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
		logic [7:0] exp;
		logic [11:0] t;
		logic ind;
		exp = 8'h00;
		ind = 1'b1;
		t = ptr_m;
		@(posedge clk_in);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(negedge clk_in);
		case (a)
			IPA_ADDR_PLAIN: t = ptr_m;
			IPA_ADDR_POST_INC: ptr_m = ptr_m + 12'h001;
			IPA_ADDR_POST_DEC: ptr_m = ptr_m - 12'h001;
			IPA_ADDR_PRE_INC: begin
				ptr_m = ptr_m + 12'h001;
				t = ptr_m;
			end
			IPA_ADDR_OFFSET: t = ptr_m + {{4{work_m[7]}}, work_m};
			default: begin
				ind = 1'b0;
				t = a;
			end
		endcase
		// Targets past the RAM read zero and drop writes, pointer still moves
		if (ind || a < DEPTH) begin
			if (t < DEPTH && w) mem_m[t] = d;
			if (t < DEPTH) exp = mem_m[t];
		end else if (w) begin
			case (a)
				IPA_ADDR_WORK: work_m = d;
				IPA_ADDR_PTR_LOW: ptr_m[7:0] = d;
				IPA_ADDR_PTR_HIGH: ptr_m[11:8] = d[3:0];
				IPA_ADDR_PC_LOW: pcw_m = d;
				default: ;
			endcase
		end else begin
			case (a)
				IPA_ADDR_WORK: exp = work_m;
				IPA_ADDR_PTR_LOW: exp = ptr_m[7:0];
				IPA_ADDR_PTR_HIGH: exp = {4'h0, ptr_m[11:8]};
				IPA_ADDR_PC_LOW: exp = pc[7:0];
				default: exp = 8'h00;
			endcase
		end
		@(posedge clk_in);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge clk_in);
		if (!w) cmp_data(rdata, exp);
		cmp_ptr(ptr, ptr_m);
		cmp_pcw({pc_wr, pc_wdata}, {w && a == IPA_ADDR_PC_LOW, pcw_m});
	endtask

	task automatic give_verdict();
		if (err_total == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Main sequence: reset, directed corners, then random traffic
	initial begin
		ptr_m = {IPA_PTR_HIGH_RST, 8'hXX};
		work_m = IPA_WORK_RST;
		pcw_m = 8'h00;
		repeat (16) @(posedge clk_in);
		reset_n_in <= 1'b1;
		cmp_ptr(ptr, ptr_m);
		acc(1'b0, IPA_ADDR_PTR_HIGH, 8'h00);
		acc(1'b0, IPA_ADDR_WORK, 8'h00);
		for (int i = 0; i < DEPTH; i++) acc(1'b1, i[11:0], 8'(next_rand() >> 8));
		acc(1'b1, IPA_ADDR_PTR_HIGH, 8'hF1);
		acc(1'b0, IPA_ADDR_PTR_HIGH, 8'h00);
		acc(1'b1, IPA_ADDR_PTR_HIGH, 8'h00);
		acc(1'b1, IPA_ADDR_PTR_LOW, 8'h05);
		acc(1'b1, IPA_ADDR_WORK, 8'hFE);
		for (int m = 0; m < 5; m++) begin
			acc(1'b0, modes[m], 8'h00);
			acc(1'b1, modes[m], 8'hC0 + m[7:0]);
			acc(1'b0, IPA_ADDR_PLAIN, 8'h00);
		end
		acc(1'b1, IPA_ADDR_PTR_LOW, 8'h0F);
		acc(1'b0, IPA_ADDR_POST_INC, 8'h00);
		acc(1'b0, IPA_ADDR_PLAIN, 8'h00);
		acc(1'b0, IPA_ADDR_POST_DEC, 8'h00);
		acc(1'b1, IPA_ADDR_PC_LOW, 8'hA5);
		acc(1'b0, IPA_ADDR_PC_LOW, 8'h00);
		acc(1'b0, 12'hFF0, 8'h00);
		for (int k = 0; k < 300; k++) begin
			r = next_rand();
			acc(r[4], map[r[3:0]], r[15:8]);
		end
		give_verdict();
	end

	// Watchdog: far beyond the roughly 700 cycles the sequence needs
	initial begin
		#2000000;
		err_total++;
		give_verdict();
	end
endmodule
`default_nettype wire
